// ---- design/adc_port_map.vh ----
// register layout and timing constants of the converter serial port
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH

// converter_setup field positions
`define SETUP_LOAD_HI        15
`define SETUP_LOAD_LO        14
`define SETUP_CHAN_HI        13
`define SETUP_CHAN_LO        11
`define SETUP_PWR_HI         10
`define SETUP_PWR_LO         9
`define SETUP_READBACK_BIT   7

// reset value: continuous operation, readback off
`define SETUP_RESET          16'h0200
// only load bits, channel, power and readback bits are kept
`define SETUP_WRITE_MASK     16'hFE80
`define SETUP_LOAD_KEY       2'h3

// serial word lengths
`define RESULT_BITS          5'h0C
`define SETUP_BITS           5'h10
`define READBACK_BITS        5'h1C

// conversion time in ns and cycle count at a 10 ns clock
`define CLK_PERIOD_NS        10
`define CONV_TIME_NS         7200
`define CONV_CYCLES          (`CONV_TIME_NS / `CLK_PERIOD_NS)
// last timer value of a conversion, kept equal to CONV_CYCLES - 1
`define CONV_LAST_CYCLE      10'h2CF

`endif

// ---- design/sync_2ff.v ----
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module sync_2ff #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// ---- design/adc_serial_conversion_port.v ----
// serial conversion control and readback port of a sampling converter
`timescale 1ns/100ps
`include "adc_port_map.vh"

module adc_serial_conversion_port #(
  parameter DIFFERENTIAL = 1'b0
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        convert_strobe,
  input  wire        sclk,
  input  wire        sdi,
  input  wire [11:0] conv_result,
  output reg         sdo_o,
  output reg         sdo_oe,
  output reg  [2:0]  channel_select,
  output reg         acquire,
  output reg         converting,
  output reg         power_down,
  output reg         sleep_mode
);

  localparam ST_IDLE = 3'b001;
  localparam ST_ACQ  = 3'b010;
  localparam ST_CONV = 3'b100;

  localparam [9:0] CONV_LAST = `CONV_LAST_CYCLE;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection

  wire [2:0] pins_s;
  reg  [2:0] pins_prev_q;
  wire       cnv_s;
  wire       sclk_s;
  wire       sdi_s;
  wire       cnv_rise;
  wire       cnv_fall;
  wire       sclk_rise;
  wire       sclk_fall;

  sync_2ff #(
    .W (3)
  ) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   ({convert_strobe, sclk, sdi}),
    .q   (pins_s)
  );

  assign cnv_s  = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  //////////////////////////////////////////////////////////////////////////
  // synchroniser warm-up

  // edges held off until both sync stages carry real pin levels;
  // a strobe idling high would otherwise look like a rise after reset
  reg  [1:0]  warm_q;
  wire        pins_ok;
  wire        sclk_live;

  always @(posedge clk) begin
    if (rst) begin
      warm_q <= 2'h0;
    end else if (warm_q != 2'h3) begin
      warm_q <= warm_q + 2'h1;
    end
  end

  assign pins_ok   = (warm_q == 2'h3);
  assign sclk_live = pins_ok & ~cnv_s;

  always @(posedge clk) begin
    if (rst) begin
      pins_prev_q <= 3'h0;
    end else begin
      pins_prev_q <= pins_s;
    end
  end

  assign cnv_rise  = pins_ok & cnv_s & ~pins_prev_q[2];
  assign cnv_fall  = pins_ok & ~cnv_s & pins_prev_q[2];
  // serial clock edges count only while the strobe is low
  assign sclk_rise = sclk_s & ~pins_prev_q[1] & sclk_live;
  assign sclk_fall = ~sclk_s & pins_prev_q[1] & sclk_live;

  //////////////////////////////////////////////////////////////////////////
  // state machine and conversion timer

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [9:0]  timer_q;
  wire        conv_done;

  assign conv_done = (state_q == ST_CONV) && (timer_q == CONV_LAST);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // a falling strobe from idle opens acquisition
        if (cnv_fall) begin
          state_d = ST_ACQ;
        end
      end
      ST_ACQ: begin
        // rising strobe at any sclk count starts the conversion
        if (cnv_rise) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        // strobe activity during conversion never restarts acquisition
        if (conv_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      timer_q <= 10'h000;
    end else begin
      state_q <= state_d;
      if (state_q != ST_CONV) begin
        timer_q <= 10'h000;
      end else if (!conv_done) begin
        timer_q <= timer_q + 10'h001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // setup word reception

  reg  [15:0] rx_sh_q;
  reg  [4:0]  rx_cnt_q;
  reg  [15:0] pend_q;
  reg         pend_vld_q;
  reg  [15:0] active_q;
  wire [15:0] rx_word;
  wire        rx_last;

  assign rx_word = {rx_sh_q[14:0], sdi_s};
  // msb arrives first, word complete on the sixteenth rising edge
  assign rx_last = sclk_rise && (rx_cnt_q == `SETUP_BITS - 5'h01);

  always @(posedge clk) begin
    if (rst) begin
      rx_sh_q    <= 16'h0000;
      rx_cnt_q   <= 5'h00;
      pend_q     <= `SETUP_RESET;
      pend_vld_q <= 1'b0;
      active_q   <= `SETUP_RESET;
    end else begin
      if (state_q == ST_IDLE && cnv_fall) begin
        rx_cnt_q <= 5'h00;
      end else if (sclk_rise && rx_cnt_q < `SETUP_BITS) begin
        rx_sh_q  <= rx_word;
        rx_cnt_q <= rx_cnt_q + 5'h01;
      end
      // held until the conversion under way completes
      if (rx_last &&
          rx_word[`SETUP_LOAD_HI:`SETUP_LOAD_LO] == `SETUP_LOAD_KEY) begin
        pend_q     <= rx_word & `SETUP_WRITE_MASK;
        pend_vld_q <= 1'b1;
      end else if (conv_done) begin
        pend_vld_q <= 1'b0;
      end
      if (conv_done && pend_vld_q) begin
        active_q <= pend_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output word capture

  reg  [27:0] out_word_q;
  wire [11:0] result_fmt;

  // core delivers offset binary; differential parts flip the msb
  assign result_fmt = DIFFERENTIAL ?
                      {~conv_result[11], conv_result[10:0]} :
                      conv_result;

  always @(posedge clk) begin
    if (rst) begin
      out_word_q <= {12'h000, `SETUP_RESET};
    end else if (conv_done) begin
      // result and the setup it was converted with, shifted next time
      out_word_q <= {result_fmt, active_q};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output shifting and end-of-conversion signalling

  reg  [4:0]  tx_cnt_q;
  reg         hold_high_q;
  reg         eoc_q;
  wire [4:0]  tx_len;
  wire [4:0]  tx_idx;
  reg         sdo_d;
  reg         sdo_oe_d;

  assign tx_len = out_word_q[`SETUP_READBACK_BIT] ?
                  `READBACK_BITS : `RESULT_BITS;
  assign tx_idx = `READBACK_BITS - tx_cnt_q;

  always @(posedge clk) begin
    if (rst) begin
      tx_cnt_q    <= 5'h00;
      hold_high_q <= 1'b0;
      eoc_q       <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && cnv_fall) begin
        tx_cnt_q <= 5'h00;
      end else if (sclk_fall && tx_cnt_q <= tx_len) begin
        // counter survives the strobe pulse so the bit is resumed
        tx_cnt_q <= tx_cnt_q + 5'h01;
      end
      // a read finished before conversion parks sdo high
      if (state_q == ST_ACQ && cnv_rise) begin
        hold_high_q <= (tx_cnt_q >= tx_len);
      end else if (state_q != ST_CONV) begin
        hold_high_q <= 1'b0;
      end
      // strobe already low at conversion end selects eoc signalling
      if (conv_done && !cnv_s) begin
        eoc_q <= 1'b1;
      end else if (cnv_rise) begin
        eoc_q <= 1'b0;
      end
    end
  end

  always @* begin
    sdo_d    = 1'b1;
    sdo_oe_d = 1'b0;
    if (cnv_s) begin
      sdo_oe_d = 1'b0;
    end else if (eoc_q) begin
      sdo_d    = 1'b0;
      sdo_oe_d = 1'b1;
    end else if (state_q == ST_CONV && hold_high_q) begin
      sdo_d    = 1'b1;
      sdo_oe_d = 1'b1;
    end else if (state_q == ST_ACQ || state_q == ST_CONV) begin
      if (tx_cnt_q == 5'h00) begin
        // waiting for the first falling edge to present the msb
        sdo_d    = 1'b1;
        sdo_oe_d = 1'b1;
      end else if (tx_cnt_q <= tx_len) begin
        sdo_d    = out_word_q[tx_idx];
        sdo_oe_d = 1'b1;
      end else begin
        sdo_oe_d = 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs

  always @(posedge clk) begin
    if (rst) begin
      sdo_o          <= 1'b1;
      sdo_oe         <= 1'b0;
      channel_select <= 3'h0;
      acquire        <= 1'b0;
      converting     <= 1'b0;
      power_down     <= 1'b0;
      sleep_mode     <= 1'b0;
    end else begin
      sdo_o  <= sdo_d;
      sdo_oe <= sdo_oe_d;
      if (DIFFERENTIAL) begin
        channel_select <= {1'b0, active_q[`SETUP_CHAN_LO+1:`SETUP_CHAN_LO]};
      end else begin
        channel_select <= active_q[`SETUP_CHAN_HI:`SETUP_CHAN_LO];
      end
      acquire    <= (state_q == ST_ACQ);
      converting <= (state_q == ST_CONV);
      // idle power state; sleep overrides power down
      power_down <= (state_q == ST_IDLE) &&
                    !active_q[`SETUP_PWR_HI] &&
                    !active_q[`SETUP_PWR_LO];
      sleep_mode <= (state_q == ST_IDLE) &&
                    active_q[`SETUP_PWR_HI];
    end
  end

endmodule

// ---- verif/adc_port_checker_assertions.sv ----
// pin-level assertions on the converter serial port
`timescale 1ns/100ps
module adc_port_checker (
  input wire        clk,
  input wire        rst,
  input wire        convert_strobe,
  input wire        sclk,
  input wire        sdi,
  input wire [11:0] conv_result,
  input wire        sdo_o,
  input wire        sdo_oe,
  input wire [2:0]  channel_select,
  input wire        acquire,
  input wire        converting,
  input wire        power_down,
  input wire        sleep_mode
);
  reg [10:0] conv_cnt_q;
  always @(posedge clk) begin
    conv_cnt_q <= (rst || !converting) ? 11'h000 : conv_cnt_q + 11'h001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // five samples cover the pin synchroniser latency
  sequence strobe_high; convert_strobe [*5]; endsequence
  sequence strobe_low; !convert_strobe [*5]; endsequence
  sequence eoc_shown; sdo_oe && !sdo_o; endsequence
  a_float_strobe: assert property (
    strobe_high |-> !sdo_oe) else $error("sdo driven with strobe high");
  a_conv_len: assert property (
    $fell(converting) |-> conv_cnt_q == 11'h2D0) else $error("conv length");
  a_idle_hold: assert property (
    $fell(converting) |-> !acquire [*4]) else $error("left idle alone");
  a_conv_start: assert property (
    $rose(converting) |-> $past(acquire) && !acquire)
    else $error("conversion not from acquisition");
  a_eoc_level: assert property (
    strobe_low ##0 $fell(converting) |-> ##[0:2] eoc_shown)
    else $error("no end of conversion level");
  a_power_idle: assert property (
    power_down || sleep_mode |-> !acquire && !converting
      && !(power_down && sleep_mode)) else $error("power state outside idle");
  a_chan_update: assert property (
    $changed(channel_select) |-> !converting && ($past(converting)
      || $past(converting, 2) || $past(converting, 3)))
    else $error("channel changed outside conversion end");
  a_acq_sdo: assert property (
    $rose(acquire) |-> ##[0:2] sdo_oe && sdo_o) else $error("sdo not high");
endmodule
bind adc_serial_conversion_port adc_port_checker adc_port_checker_inst (
  .clk(clk), .rst(rst), .convert_strobe(convert_strobe), .sclk(sclk),
  .sdi(sdi), .conv_result(conv_result), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
  .channel_select(channel_select), .acquire(acquire),
  .converting(converting), .power_down(power_down), .sleep_mode(sleep_mode));

// ---- verif/host_model.sv ----
// serial host driving strobe, serial clock and data in
`timescale 1ns/100ps
module host_model (
  input  wire clk,
  input  wire sdo_o,
  input  wire sdo_oe,
  output reg  convert_strobe,
  output reg  sclk,
  output reg  sdi
);
  wire sdo_line = sdo_oe ? sdo_o : 1'bz;
  initial begin
    convert_strobe = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // serial clock parked low so the conversion is not disturbed
  task automatic set_strobe(input logic v, input int hold);
    sclk = 1'b0;
    convert_strobe = v;
    wait_clk(hold);
  endtask
  // 80 ns period, 30 ns high; sdi set up one clock before the rise
  task automatic shift_bit(input logic d, output logic q);
    sdi = d;
    wait_clk(1);
    sclk = 1'b1;
    wait_clk(3);
    sclk = 1'b0;
    sdi = ~d;
    wait_clk(4);
    q = sdo_line;
  endtask
endmodule

// ---- verif/adc_serial_conversion_port_bench.sv ----
// self-checking bench of the converter serial port
`timescale 1ns/100ps
module adc_serial_conversion_port_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] conv_result = 12'h000;
  logic [15:0] active_q = 16'h0200;
  logic [27:0] word_q = 28'h0000000;
  logic        have_q = 1'b0;
  logic [15:0] fixed [3] = '{16'hC17F, 16'h7FFF, 16'hFFFF};
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  wire         convert_strobe, sclk, sdi, sdo_o, sdo_oe;
  wire         acquire, converting, power_down, sleep_mode;
  wire  [2:0]  channel_select;
  wire  [4:0]  setup_outs = {channel_select, power_down, sleep_mode};
  adc_serial_conversion_port adc_serial_conversion_port_inst (
    .clk(clk), .rst(rst), .convert_strobe(convert_strobe), .sclk(sclk),
    .sdi(sdi), .conv_result(conv_result), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .channel_select(channel_select), .acquire(acquire),
    .converting(converting), .power_down(power_down),
    .sleep_mode(sleep_mode));
  host_model host_model_inst (.clk(clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .convert_strobe(convert_strobe), .sclk(sclk), .sdi(sdi));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic start_conv();
    host_model_inst.set_strobe(1'b1, 10);
    check({converting, sdo_oe}, 2'h2);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (converting !== 1'b0 && n < 900) begin
      host_model_inst.wait_clk(1);
      n++;
    end
    host_model_inst.wait_clk(6);
  endtask
  // mode 0: read then strobe held high; 1: spanning; 2: read then strobe low, sdo parked high, eoc
  task automatic run_one(input int mode, input logic [15:0] w);
    logic       q;
    logic       e;
    logic [2:0] exp3;
    logic [4:0] exp5;
    int         len, k, tot;
    len = (have_q && word_q[7]) ? 28 : 12;
    tot = (len < 16) ? 16 : len + 1;
    k = (mode == 1) ? $urandom_range(len - 1) : tot;
    conv_result = 12'($urandom);
    host_model_inst.set_strobe(1'b1, 10);
    host_model_inst.set_strobe(1'b0, 8);
    check({acquire, sdo_oe, sdo_o}, 3'h7);
    for (int j = 1; j <= tot; j++) begin
      if (j == k + 1) begin
        start_conv();
        host_model_inst.set_strobe(1'b0, 8);
        e = (k == 0) ? 1'b1 : word_q[28 - k];
        if (k == 0 || have_q) check(host_model_inst.sdo_line, e);
      end
      host_model_inst.shift_bit(j <= 16 ? w[16 - j] : 1'b0, q);
      if (have_q && j <= len) check(q, word_q[28 - j]);
      if (j == len + 1) check(q, 1'bz);
    end
    if (mode != 1) start_conv();
    if (mode == 2) begin
      host_model_inst.set_strobe(1'b0, 300);
      check({sdo_oe, sdo_o}, 2'h3);
    end
    wait_idle();
    exp3 = (mode == 0) ? 3'h0 : 3'h2;
    check({acquire, sdo_oe, sdo_o & sdo_oe}, exp3);
    word_q = {conv_result, active_q};
    if (w[15:14] == 2'h3) active_q = w & 16'hFE80;
    have_q = 1'b1;
    exp5 = {active_q[13:11], active_q[10:9] == 2'h0, active_q[10]};
    check(setup_outs, exp5);
  endtask
  initial begin
    int          s;
    logic [15:0] w;
    s = $urandom(80);
    host_model_inst.wait_clk(5);
    rst = 1'b0;
    host_model_inst.wait_clk(3);
    check({power_down, sleep_mode, sdo_oe, converting}, 4'h0);
    for (int i = 0; i < 12; i++) begin
      w = (i < 3) ? fixed[i] : 16'($urandom);
      if (i >= 3 && w[14]) w[15] = 1'b1;
      run_one((i < 3) ? i : $urandom_range(2), w);
    end
    end_of_test();
  end
endmodule
